//--- logic/isp_port.sv
// Serial in-system programming port: link shifter, decoder, arrays
`timescale 1ns/100ps
// How it works
// - MOSI captured on serial clock rising edge
// - MISO changes on serial clock falling edge
// - Echo 0x53 during third enable byte
// - Page load, low byte before high
// - Page commit uses six address MSBs
// - EEPROM byte write self-erases, 4.0 ms
// - EEPROM page load then page commit
// - EEPROM commit changes loaded bytes only
// - Reads answer in the fourth byte
// - Reset pin high leaves programming mode
// - Enable is AC 53, reset low only
// - Chip erase clears flash and EEPROM
// - Program read picks low/high byte
// - EEPROM read uses 7-bit address
// - Lock bits: zero programs, read back as stored
// - Three fuse bytes written and read
// - Signature by two bits, calibration one
// - Poll returns busy in bit zero
// - Sampler tolerates minimum clock high/low
// - Erase leaves all bytes 0xFF
module isp_port #(
  parameter int         FLASH_WAIT = isp_pkg::FLASH_CYC, // Page commit time
  parameter int         EE_WAIT    = isp_pkg::EE_CYC,    // EEPROM write time
  parameter int         ERASE_WAIT = isp_pkg::ERASE_CYC, // Chip erase time
  parameter int         FUSE_WAIT  = isp_pkg::FUSE_CYC,  // Fuse and lock write time
  parameter logic [7:0] SIG0       = 8'hA5,              // Arbitrary identity value
  parameter logic [7:0] SIG1       = 8'h5A,              // Arbitrary identity value
  parameter logic [7:0] SIG2       = 8'h3C,              // Arbitrary identity value
  parameter logic [7:0] CAL0       = 8'h80               // Calibration byte
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_isp_reset_n,
  output logic            o_miso,
  output logic            o_prog_mode,
  output logic            o_busy,
  output logic [5:0]      o_lock_bits,
  output logic [7:0]      o_fuse_low,
  output logic [7:0]      o_fuse_high,
  output logic [7:0]      o_fuse_ext
);
  localparam int WW = isp_pkg::WAIT_W;

  // Link-side shifter state, serial clock rising edge
  typedef struct packed {
    logic [2:0] cnt; // Bit within the byte
    logic [6:0] sh;  // Bits gathered so far
    logic [7:0] rx;  // Last whole byte, held for the CPU side
    logic       tog; // Flips once per byte
  } isp_link_t;

  // Link-side answer state, serial clock falling edge
  typedef struct packed {
    logic       miso; // Pin driver
    logic [6:0] txs;  // Bits still to send
  } isp_tx_t;

  // CPU-side state
  typedef struct packed {
    logic                        rst_s1, rst_s2;     // Reset pin synchroniser
    logic                        tg_s1, tg_s2, tg_s3; // Byte toggle synchroniser
    logic [1:0]                  idx;                // Byte within instruction
    logic [7:0]                  b1, b2, b3;         // Bytes received so far
    logic                        prog_en;            // Programming mode
    logic [7:0]                  resp;               // Next byte to send
    logic                        busy;               // Operation pending flag
    logic [WW-1:0]               wait_cnt;           // Self-timed write wait
    isp_pkg::isp_op_t            op;                 // Background engine
    logic [isp_pkg::FL_AW-1:0]   ptr;                // Engine pointer
    logic                        pipe_v;             // Page copy write pending
    logic [isp_pkg::PB_AW-1:0]   pipe_a;             // Its byte in the page
    logic [5:0]                  fpage;              // Flash page to commit
    logic [4:0]                  epage;              // EEPROM page to commit
    logic [3:0][7:0]             eebuf;              // EEPROM page buffer
    logic [3:0]                  eeld;               // Loaded EEPROM bytes
    logic                        rd_fl, rd_ee;       // Read data due next cycle
    logic [isp_pkg::LOCK_W-1:0]  lock;
    logic [7:0]                  fuse_lo, fuse_hi, fuse_ex;
  } isp_st_t;

  isp_link_t lk, lk_nx;
  isp_tx_t   tx, tx_nx;
  isp_st_t   st, nx;
  logic      arrive; // A new byte is visible on the CPU side

  // Memory ports
  logic                      fl_we, ee_we, pb_we;
  logic [isp_pkg::FL_AW-1:0] fl_addr;
  logic [isp_pkg::EE_AW-1:0] ee_addr;
  logic [isp_pkg::PB_AW-1:0] pb_addr;
  logic [7:0]                fl_wd, ee_wd, pb_wd, fl_rd, ee_rd, pb_rd;

  // Identification byte lookup, used by the decoder
  function automatic logic [7:0] sig_byte(input logic [1:0] a);
    logic [7:0] v;
    v = isp_pkg::ERASED;
    if (a == 2'h0) begin
      v = SIG0;
    end else if (a == 2'h1) begin
      v = SIG1;
    end else if (a == 2'h2) begin
      v = SIG2;
    end
    return v;
  endfunction

  // Link byte assembly, MSB first, counter wraps every byte
  always_comb begin
    lk_nx     = lk;
    lk_nx.cnt = lk.cnt + 3'h1;
    lk_nx.sh  = {lk.sh[5:0], i_mosi};
    if (lk.cnt == 3'h7) begin
      lk_nx.rx  = {lk.sh, i_mosi};
      lk_nx.tog = ~lk.tog;
    end
  end

  // Pin reset high clears the link; the clock is held low then
  always_ff @(posedge i_sck or posedge i_isp_reset_n) begin
    if (i_isp_reset_n) begin
      lk <= '0;
    end else begin
      lk <= lk_nx;
    end
  end

  // Answer shifter: load at byte start, then shift out MSB first
  always_comb begin
    tx_nx = tx;
    if (lk.cnt == 3'h0) begin
      tx_nx.miso = st.resp[7];
      tx_nx.txs  = st.resp[6:0];
    end else begin
      tx_nx.miso = tx.txs[6];
      tx_nx.txs  = {tx.txs[5:0], 1'b0};
    end
  end

  // Resp is steady here because bytes are spaced by several CPU cycles
  always_ff @(negedge i_sck or posedge i_isp_reset_n) begin
    if (i_isp_reset_n) begin
      tx <= '0;
    end else begin
      tx <= tx_nx;
    end
  end

  assign arrive = st.tg_s2 ^ st.tg_s3;

  // CPU side: synchronisers, engine, decoder
  always_comb begin
    nx        = st;
    fl_we     = 1'b0;
    fl_addr   = st.ptr;
    fl_wd     = isp_pkg::ERASED;
    ee_we     = 1'b0;
    ee_addr   = st.ptr[isp_pkg::EE_AW-1:0];
    ee_wd     = isp_pkg::ERASED;
    pb_we     = 1'b0;
    pb_addr   = st.ptr[isp_pkg::PB_AW-1:0];
    pb_wd     = isp_pkg::ERASED;
    nx.rst_s1 = i_isp_reset_n;
    nx.rst_s2 = st.rst_s1;
    nx.tg_s1  = lk.tog;
    nx.tg_s2  = st.tg_s1;
    nx.tg_s3  = st.tg_s2;
    nx.rd_fl  = 1'b0;
    nx.rd_ee  = 1'b0;
    nx.pipe_v = 1'b0;
    // Read data lands in the fourth byte
    if (st.rd_fl) begin
      nx.resp = fl_rd;
    end else if (st.rd_ee) begin
      nx.resp = ee_rd;
    end
    if (st.wait_cnt != '0) begin
      nx.wait_cnt = st.wait_cnt - WW'(1);
    end
    // Background engine
    case (st.op)
      isp_pkg::OP_ERASE: begin
        fl_we = 1'b1;
        ee_we = (st.ptr < isp_pkg::FL_AW'(1 << isp_pkg::EE_AW));
        pb_we = (st.ptr < isp_pkg::FL_AW'(1 << isp_pkg::PB_AW));
        nx.ptr = st.ptr + isp_pkg::FL_AW'(1);
        if (st.ptr == '1) begin
          nx.op = isp_pkg::OP_IDLE;
        end
      end
      isp_pkg::OP_FLASH: begin
        // Drain the page buffer and leave it erased
        pb_we     = 1'b1;
        nx.pipe_v = 1'b1;
        nx.pipe_a = st.ptr[isp_pkg::PB_AW-1:0];
        nx.ptr    = st.ptr + isp_pkg::FL_AW'(1);
        if (st.ptr[isp_pkg::PB_AW-1:0] == '1) begin
          nx.op = isp_pkg::OP_IDLE;
        end
      end
      isp_pkg::OP_EEPAGE: begin
        ee_addr = {st.epage, st.ptr[isp_pkg::EP_AW-1:0]};
        ee_we   = st.eeld[st.ptr[isp_pkg::EP_AW-1:0]];
        ee_wd   = st.eebuf[st.ptr[isp_pkg::EP_AW-1:0]];
        nx.ptr  = st.ptr + isp_pkg::FL_AW'(1);
        if (st.ptr[isp_pkg::EP_AW-1:0] == '1) begin
          nx.op   = isp_pkg::OP_IDLE;
          nx.eeld = '0;
        end
      end
      default: begin
      end
    endcase
    // Second half of the page copy pipeline
    if (st.pipe_v) begin
      fl_we   = 1'b1;
      fl_addr = {st.fpage, st.pipe_a};
      fl_wd   = pb_rd;
    end
    // Instruction decoder
    if (st.rst_s2) begin
      nx.prog_en = 1'b0;
      nx.idx     = 2'h0;
    end else if (arrive) begin
      nx.idx  = st.idx + 2'h1;
      nx.resp = isp_pkg::ZERO_BYTE;
      case (st.idx)
        2'h0: begin
          nx.b1 = lk.rx;
        end
        2'h1: begin
          nx.b2 = lk.rx;
          if (st.b1 == isp_pkg::OPC_ENABLE && lk.rx == isp_pkg::OPC_ECHO) begin
            nx.resp = isp_pkg::OPC_ECHO;
          end
        end
        2'h2: begin
          nx.b3 = lk.rx;
          if (!st.prog_en) begin
            nx.resp = isp_pkg::ZERO_BYTE;
          end else if (st.b1 == isp_pkg::OPC_POLL) begin
            nx.resp = {7'h00, st.busy};
          end else if (st.busy) begin
            nx.resp = isp_pkg::ZERO_BYTE;
          end else if ((st.b1 & isp_pkg::H_MASK) == isp_pkg::OPC_RD_PM) begin
            fl_addr  = {st.b2[1:0], lk.rx, st.b1[isp_pkg::H_BIT]};
            nx.rd_fl = 1'b1;
          end else if (st.b1 == isp_pkg::OPC_RD_EE) begin
            ee_addr  = lk.rx[isp_pkg::EE_AW-1:0];
            nx.rd_ee = 1'b1;
          end else if (st.b1 == isp_pkg::OPC_RD_LOCK && st.b2 == isp_pkg::SUB_ZERO) begin
            nx.resp = {isp_pkg::LOCK_PAD, st.lock};
          end else if (st.b1 == isp_pkg::OPC_RD_LOCK && st.b2 == isp_pkg::SUB_HI_SEL) begin
            nx.resp = st.fuse_hi;
          end else if (st.b1 == isp_pkg::OPC_RD_FUSE) begin
            nx.resp = (st.b2 == isp_pkg::SUB_HI_SEL) ? st.fuse_ex : st.fuse_lo;
          end else if (st.b1 == isp_pkg::OPC_RD_SIG) begin
            nx.resp = sig_byte(lk.rx[1:0]);
          end else if (st.b1 == isp_pkg::OPC_RD_CAL) begin
            nx.resp = lk.rx[0] ? isp_pkg::ERASED : CAL0;
          end
        end
        default: begin
          // Fourth byte: enable or execute a write
          if (st.b1 == isp_pkg::OPC_ENABLE && st.b2 == isp_pkg::OPC_ECHO) begin
            nx.prog_en = 1'b1;
          end else if (!st.prog_en || st.busy) begin
            nx.prog_en = st.prog_en;
          end else if (st.b1 == isp_pkg::OPC_ENABLE) begin
            if (st.b2[7:5] == isp_pkg::SUB_ERASE) begin
              nx.op       = isp_pkg::OP_ERASE;
              nx.ptr      = '0;
              nx.wait_cnt = WW'(ERASE_WAIT);
              nx.lock     = '1;
              nx.eeld     = '0;
            end else if (st.b2[7:5] == isp_pkg::SUB_LOCK) begin
              nx.lock     = st.lock & lk.rx[isp_pkg::LOCK_W-1:0];
              nx.wait_cnt = WW'(FUSE_WAIT);
            end else if (st.b2 == isp_pkg::SUB_FUSE_LO) begin
              nx.fuse_lo  = lk.rx;
              nx.wait_cnt = WW'(FUSE_WAIT);
            end else if (st.b2 == isp_pkg::SUB_FUSE_HI) begin
              nx.fuse_hi  = lk.rx;
              nx.wait_cnt = WW'(FUSE_WAIT);
            end else if (st.b2 == isp_pkg::SUB_FUSE_EX) begin
              nx.fuse_ex  = {st.fuse_ex[7:1], lk.rx[0]};
              nx.wait_cnt = WW'(FUSE_WAIT);
            end
          end else if ((st.b1 & isp_pkg::H_MASK) == isp_pkg::OPC_LD_PM) begin
            pb_we   = 1'b1;
            pb_addr = {st.b3[3:0], st.b1[isp_pkg::H_BIT]};
            pb_wd   = lk.rx;
          end else if (st.b1 == isp_pkg::OPC_WR_PM) begin
            nx.op       = isp_pkg::OP_FLASH;
            nx.fpage    = {st.b2[1:0], st.b3[7:4]};
            nx.ptr      = '0;
            nx.wait_cnt = WW'(FLASH_WAIT);
          end else if (st.b1 == isp_pkg::OPC_WR_EE) begin
            ee_we       = 1'b1;
            ee_addr     = st.b3[isp_pkg::EE_AW-1:0];
            ee_wd       = lk.rx;
            nx.wait_cnt = WW'(EE_WAIT);
          end else if (st.b1 == isp_pkg::OPC_LD_EEP) begin
            nx.eebuf[st.b3[7:6]] = lk.rx;
            nx.eeld[st.b3[7:6]]  = 1'b1;
          end else if (st.b1 == isp_pkg::OPC_WR_EEP) begin
            nx.op       = isp_pkg::OP_EEPAGE;
            nx.epage    = st.b3[6:2];
            nx.ptr      = '0;
            nx.wait_cnt = WW'(EE_WAIT);
          end
        end
      endcase
    end
    nx.busy = (nx.op != isp_pkg::OP_IDLE) || (nx.wait_cnt != '0);
  end

  // CPU-side register; clock enable low freezes it
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st         <= '0;
      st.lock    <= '1;
      st.fuse_lo <= isp_pkg::FUSE_LO_RST;
      st.fuse_hi <= isp_pkg::FUSE_HI_RST;
      st.fuse_ex <= isp_pkg::FUSE_EX_RST;
    end else if (i_ce) begin
      st <= nx;
    end
  end

  // Flash array, page buffer, EEPROM array
  isp_mem #(.WIDTH(8), .DEPTH(1 << isp_pkg::FL_AW), .AW(isp_pkg::FL_AW)) u_flash (
    .i_ref_clk(i_ref_clk), .i_ce(i_ce), .i_we(fl_we), .i_addr(fl_addr), .i_wdata(fl_wd), .o_rdata(fl_rd));
  isp_mem #(.WIDTH(8), .DEPTH(1 << isp_pkg::PB_AW), .AW(isp_pkg::PB_AW)) u_pbuf (
    .i_ref_clk(i_ref_clk), .i_ce(i_ce), .i_we(pb_we), .i_addr(pb_addr), .i_wdata(pb_wd), .o_rdata(pb_rd));
  isp_mem #(.WIDTH(8), .DEPTH(1 << isp_pkg::EE_AW), .AW(isp_pkg::EE_AW)) u_eeprom (
    .i_ref_clk(i_ref_clk), .i_ce(i_ce), .i_we(ee_we), .i_addr(ee_addr), .i_wdata(ee_wd), .o_rdata(ee_rd));

  // Outputs straight from state flops
  assign o_miso      = tx.miso;
  assign o_prog_mode = st.prog_en;
  assign o_busy      = st.busy;
  assign o_lock_bits = st.lock;
  assign o_fuse_low  = st.fuse_lo;
  assign o_fuse_high = st.fuse_hi;
  assign o_fuse_ext  = st.fuse_ex;

  // Checks on the CPU side
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n || !i_ce);

  sequence s_enable_second;
    arrive && !st.rst_s2 && st.idx == 2'h1 && st.b1 == isp_pkg::OPC_ENABLE && lk.rx == isp_pkg::OPC_ECHO;
  endsequence

  a_echo_byte: assert property (s_enable_second |=> st.resp == isp_pkg::OPC_ECHO)
    else $error("enable echo missing");
  a_pin_exit: assert property (st.rst_s2 |=> !st.prog_en && st.idx == 2'h0)
    else $error("programming mode kept with reset pin high");
  a_locked_idle: assert property ($rose(st.op != isp_pkg::OP_IDLE) |-> $past(st.prog_en))
    else $error("operation started before enabling");
  a_idx_wrap: assert property (arrive && !st.rst_s2 && st.idx == 2'h3 |=> st.idx == 2'h0)
    else $error("byte counter did not wrap");
  a_poll_answer: assert property (arrive && !st.rst_s2 && st.idx == 2'h2 && st.prog_en
                                  && st.b1 == isp_pkg::OPC_POLL |=> st.resp == {7'h00, $past(st.busy)})
    else $error("poll answer differs from busy");
  a_erase_runs: assert property ($rose(st.op == isp_pkg::OP_ERASE)
                                 |-> st.wait_cnt == WW'(ERASE_WAIT) ##1 (st.op == isp_pkg::OP_ERASE && st.busy) [*8])
    else $error("chip erase cut short");
  a_flash_wait: assert property ($rose(st.op == isp_pkg::OP_FLASH) |-> st.wait_cnt == WW'(FLASH_WAIT) && st.busy)
    else $error("flash wait not loaded");
  a_lock_only_prog: assert property (st.op != isp_pkg::OP_ERASE ##1 st.op != isp_pkg::OP_ERASE
                                     |-> (st.lock & ~$past(st.lock)) == '0)
    else $error("lock bit unprogrammed without erase");
  a_eepage_clears: assert property ($fell(st.op == isp_pkg::OP_EEPAGE) |-> st.eeld == '0)
    else $error("EEPROM page flags left set");
endmodule

//--- logic/isp_pkg.sv
// Shared opcodes, sizes, timing and types of the serial programming port
package isp_pkg;
  // Instruction first bytes
  localparam logic [7:0] OPC_ENABLE  = 8'hAC; // Enable, erase, lock and fuse writes
  localparam logic [7:0] OPC_ECHO    = 8'h53; // Second enable byte, echoed back
  localparam logic [7:0] OPC_RD_PM   = 8'h20; // Program read, H bit cleared
  localparam logic [7:0] OPC_LD_PM   = 8'h40; // Program page load, H bit cleared
  localparam logic [7:0] OPC_WR_PM   = 8'h4C; // Program page commit
  localparam logic [7:0] OPC_RD_EE   = 8'hA0; // Data EEPROM byte read
  localparam logic [7:0] OPC_WR_EE   = 8'hC0; // Data EEPROM byte write
  localparam logic [7:0] OPC_LD_EEP  = 8'hC1; // Data EEPROM page load
  localparam logic [7:0] OPC_WR_EEP  = 8'hC2; // Data EEPROM page commit
  localparam logic [7:0] OPC_RD_LOCK = 8'h58; // Lock read, or high fuse read
  localparam logic [7:0] OPC_RD_FUSE = 8'h50; // Low or extended fuse read
  localparam logic [7:0] OPC_RD_SIG  = 8'h30; // Identification byte read
  localparam logic [7:0] OPC_RD_CAL  = 8'h38; // Calibration byte read
  localparam logic [7:0] OPC_POLL    = 8'hF0; // Busy poll
  // Second byte selectors
  localparam logic [2:0] SUB_ERASE   = 3'h4;  // Top three bits 100
  localparam logic [2:0] SUB_LOCK    = 3'h7;  // Top three bits 111
  localparam logic [7:0] SUB_FUSE_LO = 8'hA0;
  localparam logic [7:0] SUB_FUSE_HI = 8'hA8;
  localparam logic [7:0] SUB_FUSE_EX = 8'hA4;
  localparam logic [7:0] SUB_HI_SEL  = 8'h08; // Picks high or extended fuse on read
  localparam logic [7:0] SUB_ZERO    = 8'h00;
  localparam logic [7:0] H_MASK      = 8'hF7; // Clears the high/low byte select
  localparam int         H_BIT       = 3;
  // Data values
  localparam logic [7:0] ERASED      = 8'hFF;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;
  localparam logic [1:0] LOCK_PAD    = 2'h3;  // Unused lock read bits
  localparam logic [7:0] FUSE_LO_RST = 8'hFF;
  localparam logic [7:0] FUSE_HI_RST = 8'hFF;
  localparam logic [7:0] FUSE_EX_RST = 8'hFF;
  // Array sizes
  localparam int FL_AW  = 11; // Flash byte address
  localparam int PB_AW  = 5;  // Bytes in one flash page
  localparam int EE_AW  = 7;  // EEPROM byte address
  localparam int EP_AW  = 2;  // Bytes in one EEPROM page
  localparam int LOCK_W = 6;
  localparam int WAIT_W = 20; // Holds the longest wait count
  // Timing
  localparam real REF_CLK_MHZ = 100.0;
  localparam real T_FLASH_MS  = 4.5;
  localparam real T_EE_MS     = 4.0;
  localparam real T_ERASE_MS  = 4.0;
  localparam real T_FUSE_MS   = 4.5;
  localparam int FLASH_CYC = int'($ceil(T_FLASH_MS * 1.0E3 * REF_CLK_MHZ));
  localparam int EE_CYC    = int'($ceil(T_EE_MS * 1.0E3 * REF_CLK_MHZ));
  localparam int ERASE_CYC = int'($ceil(T_ERASE_MS * 1.0E3 * REF_CLK_MHZ));
  localparam int FUSE_CYC  = int'($ceil(T_FUSE_MS * 1.0E3 * REF_CLK_MHZ));
  // Background operation engine
  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_FLASH, OP_EEPAGE} isp_op_t;
endpackage

//--- logic/isp_mem.sv
// Single-port byte memory with registered read data
`timescale 1ns/100ps
module isp_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_ce,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_addr,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage array

  // Read before write, so a copy can drain and refill in one pass
  always_ff @(posedge i_ref_clk) begin
    if (i_ce) begin
      o_rdata <= mem[i_addr];
      if (i_we) begin
        mem[i_addr] <= i_wdata;
      end
    end
  end
endmodule

//--- testbench/isp_programmer.sv
// Programmer model: drives the serial link and the reset pin
`timescale 1ns/100ps
module isp_programmer #(
  parameter int POWER_WAIT_NS = 20000000 // Settle time before enabling
) (
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_isp_reset_n
);
  // Power-up with reset pin and clock low, then one pin pulse
  // Link flops have no other reset, so they wake up unknown without it
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_isp_reset_n = 1'b0;
    #20;
    o_isp_reset_n = 1'b1;
    #100;
    o_isp_reset_n = 1'b0;
  end
  // Settle before the first enable
  task automatic settle();
    #(POWER_WAIT_NS);
  endtask
  // Positive pulse on the pin with the clock held low
  task automatic pulse_reset();
    o_sck = 1'b0;
    o_isp_reset_n = 1'b1;
    #100;
    o_isp_reset_n = 1'b0;
    #100;
  endtask
  // Always four whole bytes, MSB first; clock rests high between bytes
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
    for (int i = 31; i >= 0; i--) begin
      o_mosi = cmd[i];
      #3 o_sck = 1'b1;
      rsp[i] = i_miso;
      #3;
      if (i % 8 != 0) o_sck = 1'b0;
      else begin
        // Released data line must not keep its last level
        o_mosi = ~o_mosi;
        // Long rest so the answer byte is ready at the next fall
        #100 o_sck = 1'b0;
        #3;
      end
    end
  endtask
endmodule

//--- testbench/serial_isp_programming_port_bench.sv
// Self-checking bench of the serial programming port
`timescale 1ns/100ps
module serial_isp_programming_port_bench;
  localparam logic [7:0] SUB [3] = '{isp_pkg::SUB_FUSE_LO, isp_pkg::SUB_FUSE_HI, isp_pkg::SUB_FUSE_EX};
  localparam logic [7:0] RD1 [3] = '{isp_pkg::OPC_RD_FUSE, isp_pkg::OPC_RD_LOCK, isp_pkg::OPC_RD_FUSE};
  localparam logic [7:0] RD2 [3] = '{isp_pkg::SUB_ZERO, isp_pkg::SUB_HI_SEL, isp_pkg::SUB_HI_SEL};
  localparam logic [7:0] IDV [6] = '{8'hA5, 8'h5A, 8'h3C, 8'hFF, 8'h80, 8'hFF}; // Default ids, unused slots FF
  logic        i_ref_clk;
  logic        i_rst_n;
  logic        ce;                  // Clock enable of the CPU side
  logic        sck, mosi, pin_rst_n, miso, prog, busy;
  logic [5:0]  lock;
  logic [7:0]  fuse [3];
  logic [31:0] rsp;                 // Last answer word
  logic [31:0] seed = 32'h00000053; // Xorshift state
  int          err_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          ee [int];            // EEPROM model, absent means erased
  isp_port #(.FLASH_WAIT(100), .EE_WAIT(100), .ERASE_WAIT(2200), .FUSE_WAIT(100)) u_dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_sck(sck), .i_mosi(mosi),
    .i_isp_reset_n(pin_rst_n), .o_miso(miso), .o_prog_mode(prog), .o_busy(busy), .o_lock_bits(lock),
    .o_fuse_low(fuse[0]), .o_fuse_high(fuse[1]), .o_fuse_ext(fuse[2]));
  isp_programmer #(.POWER_WAIT_NS(1000)) u_prog (
    .i_miso(miso), .o_sck(sck), .o_mosi(mosi), .o_isp_reset_n(pin_rst_n));
  // Reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Hang guard
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      end_of_test();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4);
    u_prog.xfer({b1, b2, b3, b4}, rsp);
  endtask
  // Poll until the pending flag clears, bounded
  task automatic idle();
    int n = 0;
    do begin
      cmd(isp_pkg::OPC_POLL, 8'h00, 8'h00, 8'h00);
      n++;
    end while (rsp[0] !== 1'b0 && n < 100);
    chk({7'h00, rsp[0]}, 8'h00);
  endtask
  // Compare one EEPROM page against the model
  task automatic ee_check();
    for (int a = 4; a < 8; a++) begin
      cmd(isp_pkg::OPC_RD_EE, 8'h00, 8'(a), 8'h00);
      chk(rsp[7:0], ee.exists(a) ? 8'(ee[a]) : 8'hFF);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] w;
    i_rst_n = 1'b0;
    ce = 1'b1;
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    chk({2'h0, lock}, 8'h3F);
    for (int i = 0; i < 3; i++) chk(fuse[i], 8'hFF);
    u_prog.settle();
    // Ignored before enabling
    cmd(isp_pkg::OPC_RD_SIG, 8'h00, 8'h00, 8'h00);
    chk(rsp[7:0], 8'h00);
    cmd(isp_pkg::OPC_ENABLE, isp_pkg::OPC_ECHO, 8'h00, 8'h00);
    chk(rsp[15:8], isp_pkg::OPC_ECHO);
    repeat (10) @(posedge i_ref_clk);
    chk({7'h00, prog}, 8'h01);
    // Chip erase, busy seen, then all ones
    cmd(isp_pkg::OPC_ENABLE, 8'h80, 8'h00, 8'h00);
    cmd(isp_pkg::OPC_POLL, 8'h00, 8'h00, 8'h00);
    chk({7'h00, rsp[0]}, 8'h01);
    idle();
    ee_check();
    cmd(isp_pkg::OPC_RD_PM, 8'h00, 8'h23, 8'h00);
    chk(rsp[7:0], 8'hFF);
    // Byte writes, the second over the first
    for (int k = 0; k < 2; k++) begin
      v = rnd();
      cmd(isp_pkg::OPC_WR_EE, 8'h00, 8'h05, v);
      if (k == 0) begin
        // Enable low freezes the write wait, so the flag must outlast it
        @(posedge i_ref_clk);
        ce <= 1'b0;
        repeat (200) @(posedge i_ref_clk);
        chk({7'h00, busy}, 8'h01);
        ce <= 1'b1;
      end
      idle();
      ee[5] = v;
      ee_check();
    end
    // Page write alters only the loaded byte
    v = rnd();
    cmd(isp_pkg::OPC_LD_EEP, 8'h00, 8'h80, v);
    cmd(isp_pkg::OPC_WR_EEP, 8'h00, 8'h04, 8'h00);
    idle();
    ee[6] = v;
    ee_check();
    // Flash word 0x23: low then high, commit page 2
    v = rnd();
    w = rnd();
    cmd(isp_pkg::OPC_LD_PM, 8'h00, 8'h03, v);
    cmd(isp_pkg::OPC_LD_PM | 8'h08, 8'h00, 8'h03, w);
    cmd(isp_pkg::OPC_WR_PM, 8'h00, 8'h20, 8'h00);
    idle();
    cmd(isp_pkg::OPC_RD_PM, 8'h00, 8'h23, 8'h00);
    chk(rsp[7:0], v);
    cmd(isp_pkg::OPC_RD_PM | 8'h08, 8'h00, 8'h23, 8'h00);
    chk(rsp[7:0], w);
    // Lock bits
    v = rnd();
    cmd(isp_pkg::OPC_ENABLE, 8'hE0, 8'h00, {2'h3, v[5:0]});
    idle();
    chk({2'h0, lock}, {2'h0, v[5:0]});
    cmd(isp_pkg::OPC_RD_LOCK, 8'h00, 8'h00, 8'h00);
    chk(rsp[7:0], {isp_pkg::LOCK_PAD, v[5:0]});
    // Fuse bytes, extended keeps only bit zero
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      w = (i == 2) ? {7'h7F, v[0]} : v;
      cmd(isp_pkg::OPC_ENABLE, SUB[i], 8'h00, v);
      idle();
      chk(fuse[i], w);
      cmd(RD1[i], RD2[i], 8'h00, 8'h00);
      chk(rsp[7:0], w);
    end
    // Identification and calibration bytes
    for (int i = 0; i < 6; i++) begin
      cmd(i < 4 ? isp_pkg::OPC_RD_SIG : isp_pkg::OPC_RD_CAL, 8'h00, 8'(i % 4), 8'h00);
      chk(rsp[7:0], IDV[i]);
    end
    // Pin released high leaves programming mode
    u_prog.pulse_reset();
    chk({7'h00, prog}, 8'h00);
    cmd(isp_pkg::OPC_RD_LOCK, 8'h00, 8'h00, 8'h00);
    chk(rsp[7:0], 8'h00);
    end_of_test();
  end
endmodule
